// ===== src/pds_top.sv
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
// Contract
// - 0x0F0 bits 2:0 hold a read-write mode field for port 0 pin 4.
// - 0x0F8 bits 6:4 hold a read-write mode field for port 1 pin 1.
// - 0x0F8 bits 2:0 hold a read-write mode field for port 1 pin 0.
// - On the 0x0EC low field, codes 0,1,2 pick strong sharp, medium, soft edges.
// - Codes 011 and 111 pick weak; 100, 101, 110 pick medium, on the 0x0EC low field, the only decoded one.
// - Single reserved bits 7 and 3 read as zero; software writes zero.
// - Bits 6:4 at 0x0F0 read as 100; software writes 100.
// - All three registers reset to 0x44, every field to medium.
module pds_top (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [11:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic [2:0] o_p0_pin2_drive_sel,
  output logic [2:0] o_p0_pin3_drive_sel,
  output logic [2:0] o_p0_pin4_drive_sel,
  output logic [2:0] o_p1_pin0_drive_sel,
  output logic [2:0] o_p1_pin1_drive_sel,
  output logic [2:0] o_p0_pin2_drive_cls
);
  // field index: 0 p0.2, 1 p0.3, 2 p0.4, 3 p1.0, 4 p1.1
  logic [2:0] fld_q [pds_pkg::NUM_FIELDS];
  logic [pds_pkg::NUM_FIELDS-1:0] fld_we;
  logic [2:0] fld_wdata [pds_pkg::NUM_FIELDS];
  logic sel_a;
  logic sel_b;
  logic sel_c;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  pds_pkg::pds_drv_e cls_d;
  logic [2:0] cls_q;

  // address decode; only the coded offsets are mapped
  assign sel_a = (i_addr == pds_pkg::PORT0_DRIVE_CTRL_A_OFS);
  assign sel_b = (i_addr == pds_pkg::PORT0_DRIVE_CTRL_B_OFS);
  assign sel_c = (i_addr == pds_pkg::PORT1_DRIVE_CTRL_A_OFS);

  // write enables per field; reserved bit lanes never reach storage
  assign fld_we[0] = i_wr && sel_a;
  assign fld_we[1] = i_wr && sel_a;
  assign fld_we[2] = i_wr && sel_b;
  assign fld_we[3] = i_wr && sel_c;
  assign fld_we[4] = i_wr && sel_c;
  assign fld_wdata[0] = i_wdata[pds_pkg::LO_FLD_LSB +: pds_pkg::FLD_W];
  assign fld_wdata[1] = i_wdata[pds_pkg::HI_FLD_LSB +: pds_pkg::FLD_W];
  assign fld_wdata[2] = i_wdata[pds_pkg::LO_FLD_LSB +: pds_pkg::FLD_W];
  assign fld_wdata[3] = i_wdata[pds_pkg::LO_FLD_LSB +: pds_pkg::FLD_W];
  assign fld_wdata[4] = i_wdata[pds_pkg::HI_FLD_LSB +: pds_pkg::FLD_W];

  // one storage cell per field, all reset to medium
  genvar gi;
  generate
    for (gi = 0; gi < pds_pkg::NUM_FIELDS; gi++) begin : g_fld
      pds_field u_fld (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_we(fld_we[gi]),
        .i_wdata(fld_wdata[gi]),
        .o_q(fld_q[gi])
      );
    end
  endgenerate

  // read mux; reserved single bits read zero, 0x0F0 bits 6:4 read 100
  always_comb begin
    rdata_d = pds_pkg::RD_UNMAPPED;
    if (sel_a) begin
      rdata_d = {1'b0, fld_q[1], 1'b0, fld_q[0]};
    end else if (sel_b) begin
      rdata_d = {1'b0, pds_pkg::B_RES_HI_VAL, 1'b0, fld_q[2]};
    end else if (sel_c) begin
      rdata_d = {1'b0, fld_q[4], 1'b0, fld_q[3]};
    end
  end

  // read data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_q <= pds_pkg::RD_UNMAPPED;
    end else if (i_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= pds_pkg::RD_UNMAPPED;
    end
  end
  assign o_rdata = rdata_q;

  // decoded class for the only strong-capable pin in this set
  pds_decode u_dec (
    .i_code(fld_q[0]),
    .i_strong_ok(1'b1),
    .o_drv(cls_d)
  );

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cls_q <= 3'(pds_pkg::PDS_DRV_MEDIUM);
    end else begin
      cls_q <= 3'(cls_d);
    end
  end
  assign o_p0_pin2_drive_cls = cls_q;

  // stored fields drive the pads straight from their flops
  assign o_p0_pin2_drive_sel = fld_q[0];
  assign o_p0_pin3_drive_sel = fld_q[1];
  assign o_p0_pin4_drive_sel = fld_q[2];
  assign o_p1_pin0_drive_sel = fld_q[3];
  assign o_p1_pin1_drive_sel = fld_q[4];
endmodule : pds_top

// ===== src/pds_pkg.sv
package pds_pkg;
  // register offsets (byte addresses on the register port)
  localparam logic [11:0] PORT0_DRIVE_CTRL_A_OFS = 12'h0EC;
  localparam logic [11:0] PORT0_DRIVE_CTRL_B_OFS = 12'h0F0;
  localparam logic [11:0] PORT1_DRIVE_CTRL_A_OFS = 12'h0F8;
  // field layout
  localparam int FLD_W = 3;
  localparam int LO_FLD_LSB = 0;
  localparam int HI_FLD_LSB = 4;
  // reset values
  localparam logic [7:0] DRIVE_CTRL_RST = 8'h44;
  localparam logic [2:0] FLD_RST = 3'h4;
  // fixed reserved read values
  localparam logic [2:0] B_RES_HI_VAL = 3'h4;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // driver-mode codes
  localparam logic [2:0] MODE_STRONG_SHARP = 3'h0;
  localparam logic [2:0] MODE_STRONG_MED = 3'h1;
  localparam logic [2:0] MODE_STRONG_SOFT = 3'h2;
  localparam logic [2:0] MODE_WEAK_A = 3'h3;
  localparam logic [2:0] MODE_WEAK_B = 3'h7;
  localparam int NUM_FIELDS = 5;

  // decoded driver class handed to the pads
  typedef enum logic [2:0] {
    PDS_DRV_STRONG_SHARP,
    PDS_DRV_STRONG_MED,
    PDS_DRV_STRONG_SOFT,
    PDS_DRV_WEAK,
    PDS_DRV_MEDIUM
  } pds_drv_e;
endpackage : pds_pkg

// ===== src/pds_field.sv
`timescale 1ns/1ps
// one 3-bit driver-mode field, reset to the medium code
module pds_field (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_we,
  input wire logic [2:0] i_wdata,
  output logic [2:0] o_q
);
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_q <= pds_pkg::FLD_RST;
    end else if (i_we) begin
      o_q <= i_wdata;
    end
  end
endmodule : pds_field

// ===== src/pds_decode.sv
`timescale 1ns/1ps
// maps a driver-mode code to its driver class
module pds_decode (
  input wire logic [2:0] i_code,
  input wire logic i_strong_ok,
  output pds_pkg::pds_drv_e o_drv
);
  always_comb begin
    unique case (i_code)
      pds_pkg::MODE_STRONG_SHARP: o_drv = pds_pkg::PDS_DRV_STRONG_SHARP;
      pds_pkg::MODE_STRONG_MED: o_drv = pds_pkg::PDS_DRV_STRONG_MED;
      pds_pkg::MODE_STRONG_SOFT: o_drv = pds_pkg::PDS_DRV_STRONG_SOFT;
      pds_pkg::MODE_WEAK_A, pds_pkg::MODE_WEAK_B: o_drv = pds_pkg::PDS_DRV_WEAK;
      default: o_drv = pds_pkg::PDS_DRV_MEDIUM;
    endcase
    // codes 0..2 are unused on pins lacking a strong driver; fall back to medium
    if (!i_strong_ok && (i_code < pds_pkg::MODE_WEAK_A)) begin
      o_drv = pds_pkg::PDS_DRV_MEDIUM;
    end
  end
endmodule : pds_decode

// ===== tb/pds_top_assertions.sv
`timescale 1ns/1ps
module pds_top_assertions (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [11:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [2:0] o_p0_pin2_drive_sel,
  input wire logic [2:0] o_p0_pin3_drive_sel,
  input wire logic [2:0] o_p0_pin4_drive_sel,
  input wire logic [2:0] o_p1_pin0_drive_sel,
  input wire logic [2:0] o_p1_pin1_drive_sel,
  input wire logic [2:0] o_p0_pin2_drive_cls
);
  logic [7:0] wd_q;
  // write data one cycle back, so the field checks need no slice of $past
  always_ff @(posedge i_clk) wd_q <= i_wdata;
  // driver class that a code must give on the strong-capable field
  function automatic logic [2:0] cls_of(logic [2:0] c);
    if (c < 3'h3) return c;
    return (c[1:0] == 2'h3) ? 3'h3 : 3'h4;
  endfunction : cls_of
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_idle_zero: assert property (!i_rd |=> o_rdata == 8'h00) else $error("rdata not idle");
  a_rd_ctrl_a: assert property (i_rd && i_addr == 12'h0EC |=>
    o_rdata == {1'b0, o_p0_pin3_drive_sel, 1'b0, o_p0_pin2_drive_sel}) else $error("rd 0EC");
  a_rd_ctrl_b: assert property (i_rd && i_addr == 12'h0F0 |=>
    o_rdata == {4'h4, 1'b0, o_p0_pin4_drive_sel}) else $error("rd 0F0");
  a_rd_port1: assert property (i_rd && i_addr == 12'h0F8 |=>
    o_rdata == {1'b0, o_p1_pin1_drive_sel, 1'b0, o_p1_pin0_drive_sel}) else $error("rd 0F8");
  a_wr_ctrl_a: assert property (i_wr && i_addr == 12'h0EC |=>
    o_p0_pin3_drive_sel == wd_q[6:4] && o_p0_pin2_drive_sel == wd_q[2:0]) else $error("wr 0EC");
  a_wr_ctrl_b: assert property (i_wr && i_addr == 12'h0F0 |=>
    o_p0_pin4_drive_sel == wd_q[2:0]) else $error("wr 0F0");
  a_wr_port1: assert property (i_wr && i_addr == 12'h0F8 |=>
    o_p1_pin1_drive_sel == wd_q[6:4] && o_p1_pin0_drive_sel == wd_q[2:0]) else $error("wr 0F8");
  a_hold_fields: assert property (!i_wr |=> $stable({o_p0_pin2_drive_sel, o_p0_pin3_drive_sel,
    o_p0_pin4_drive_sel, o_p1_pin0_drive_sel, o_p1_pin1_drive_sel})) else $error("field moved");
  a_cls_map: assert property (o_p0_pin2_drive_cls == cls_of($past(o_p0_pin2_drive_sel)))
    else $error("class");
  c_wr_b: cover property (i_wr && i_addr == 12'h0F0);
  c_soft: cover property (o_p0_pin2_drive_cls == 3'h2);
  c_weak: cover property (o_p0_pin2_drive_cls == 3'h3);
endmodule : pds_top_assertions

// ===== tb/test_port_drive_strength_regs.sv
`timescale 1ns/1ps
module test_port_drive_strength_regs;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic [11:0] i_addr = 12'h000;
  logic [7:0] i_wdata = 8'h00, o_rdata, d;
  logic [2:0] o_p0_pin2_drive_sel, o_p0_pin3_drive_sel, o_p0_pin4_drive_sel;
  logic [2:0] o_p1_pin0_drive_sel, o_p1_pin1_drive_sel, o_p0_pin2_drive_cls;
  logic [11:0] adr [4] = '{12'h0EC, 12'h0F0, 12'h0F8, 12'h0F4};
  logic [7:0] mdl [4] = '{8'h44, 8'h44, 8'h44, 8'h00};
  int error_cnt = 0, n_checks = 0, cyc = 0, seed = 29;
  pds_top DUT (.*);
  always #50 i_clk = ~i_clk;
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // 0x0F0 keeps 100 in its upper field; unmapped place stores nothing
  function automatic logic [7:0] rd_exp(logic [11:0] a, logic [7:0] v);
    if (a == 12'h0F4) return 8'h00;
    return (a == 12'h0F0) ? {5'h08, v[2:0]} : (v & 8'h77);
  endfunction : rd_exp
  // what software may legally write: no strong codes on weak-only pins, reserved bits as required
  function automatic logic [7:0] legal(logic [11:0] a, logic [7:0] v);
    logic [2:0] lo, hi;
    lo = v[2:0];
    hi = v[6:4];
    if (hi < 3'h3) hi = hi + 3'h3;
    if (a != 12'h0EC && lo < 3'h3) lo = lo + 3'h3;
    if (a == 12'h0F0) hi = 3'h4;
    return {1'b0, hi, 1'b0, lo};
  endfunction : legal
  task automatic wr(logic [11:0] a, logic [7:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [11:0] a, logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk("rdata", o_rdata, e);
  endtask : rd
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // hang guard, well above the roughly 240 cycles the sequence needs
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    for (int k = 0; k < 4; k++) rd(adr[k], mdl[k]);
    chk("cls", {5'h00, o_p0_pin2_drive_cls}, 8'h04);
    // every code on the strong-capable field; class lags the field by one cycle
    for (int k = 0; k < 8; k++) begin
      wr(12'h0EC, 8'h40 | 8'(k));
      @(posedge i_clk);
      #1 chk("cls", {5'h00, o_p0_pin2_drive_cls}, (k < 3) ? 8'(k) : (k[1:0] == 2'h3 ? 8'h03 : 8'h04));
    end
    mdl[0] = 8'h47;
    for (int k = 0; k < 32; k++) begin
      d = legal(adr[k % 4], (k < 4) ? 8'hFF : 8'($random(seed)));
      wr(adr[k % 4], d);
      mdl[k % 4] = rd_exp(adr[k % 4], d);
      rd(adr[k % 4], mdl[k % 4]);
      rd(adr[(k + 1) % 4], mdl[(k + 1) % 4]);
    end
    // every pad output must show its stored field
    chk("pin2", {5'h00, o_p0_pin2_drive_sel}, {5'h00, mdl[0][2:0]});
    chk("pin3", {5'h00, o_p0_pin3_drive_sel}, {5'h00, mdl[0][6:4]});
    chk("pin4", {5'h00, o_p0_pin4_drive_sel}, {5'h00, mdl[1][2:0]});
    chk("p1pin0", {5'h00, o_p1_pin0_drive_sel}, {5'h00, mdl[2][2:0]});
    chk("p1pin1", {5'h00, o_p1_pin1_drive_sel}, {5'h00, mdl[2][6:4]});
    // reset in mid-run must bring every register back to medium
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    for (int k = 0; k < 4; k++) rd(adr[k], (k == 3) ? 8'h00 : 8'h44);
    chk("cls", {5'h00, o_p0_pin2_drive_cls}, 8'h04);
    end_of_test();
  end
endmodule : test_port_drive_strength_regs
bind pds_top pds_top_assertions u_chk (.*);
